/* File: common/pixel_readout_pkg.sv */
/*
  Shared constants and state types for the pixel row readout control block.
  Assumes a 250 MHz core clock and a slower master clock from the controller.
*/
package pixel_readout_pkg;

  // ------------------------------------------------------------------
  // geometry and timing
  // ------------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS = 4;
  localparam int unsigned CAL_TIME_NS    = 2000;
  localparam int unsigned CAL_CYCLES     = (CAL_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned PIX_W          = 10;
  localparam int unsigned GROUP_PIX      = 10;
  localparam int unsigned BUS_W          = 100;
  localparam int unsigned COL_W          = 7;
  localparam int unsigned ROW_W          = 10;
  localparam int unsigned CNT_W          = 9;
  localparam logic [COL_W-1:0] LAST_GROUP = 7'h7f;
  localparam logic [CNT_W-1:0] CAL_LAST   = CNT_W'(CAL_CYCLES - 1);
  localparam logic [1:0]       PULSE_IDLE = 2'h3;
  localparam logic [1:0]       PULSE_FIRE = 2'h0;

  // ------------------------------------------------------------------
  // state types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CORE_IDLE = 2'b00,
    CORE_CAL  = 2'b01,
    CORE_CONV = 2'b10
  } core_state_t;

  typedef struct packed {
    logic [1:0]       cal_run;
    logic [1:0]       conv_run;
    logic             cal_req;
    logic             conv_req;
    logic [2:0]       cal_ack;
    logic [2:0]       conv_ack;
    logic [1:0]       cal_done_n;
    logic [1:0]       row_done_n;
    logic             latest_bank;
    logic             bank;
    logic             sense;
    logic [COL_W-1:0] col;
    logic [BUS_W-1:0] data;
  } link_t;

  typedef struct packed {
    core_state_t      state;
    logic [2:0]       cal_req;
    logic [2:0]       conv_req;
    logic [1:0]       standby;
    logic [1:0]       dark;
    logic [ROW_W-1:0] addr_s1;
    logic [ROW_W-1:0] addr_s2;
    logic [2*PIX_W-1:0] ref_s1;
    logic [2*PIX_W-1:0] ref_s2;
    logic [ROW_W-1:0] row_sel;
    logic [CNT_W-1:0] cnt;
    logic [COL_W-1:0] grp;
    logic             wr_bank;
    logic             cal_ack;
    logic             conv_ack;
  } core_t;

endpackage

/* File: verilog/pixel_row_readout_control.sv */
/*
  Digital control and readout of a column-parallel sensor row.
  Assumes controller pins are synchronous to MASTER_CLOCK_IN, the ADC array
  presents one digitised column group per MCLK cycle on PIXEL_SAMPLE, and pad
  pull-ups on DARK_OFFSET_EN_N and STANDBY_N resolve undriven pins high.
*/
`timescale 1ns/1ns
`default_nettype none
module pixel_row_readout_control
  import pixel_readout_pkg::*;
(
  // core clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RST,
  // controller link
  input  wire logic                   MASTER_CLOCK_IN,
  input  wire logic                   LOGIC_RESET_LOW,
  input  wire logic                   CALIB_BEGIN_PULSE_N,
  output logic                        CALIB_DONE_N,
  input  wire logic                   ROW_CONVERT_PULSE_N,
  output logic                        ROW_DONE_N,
  input  wire logic                   ROW_LOAD_ENVELOPE_N,
  input  wire logic                   READ_ENABLE_N,
  input  wire logic                   DARK_OFFSET_EN_N,
  input  wire logic                   STANDBY_N,
  input  wire logic [ROW_W-1:0]       ROW_ADDRESS,
  output logic [BUS_W-1:0]            PIXEL_DATA,
  output logic                        PIXEL_CLK_OUT,
  // analog front end
  input  wire logic [PIX_W-1:0]       OFFSET_REFERENCE_A,
  input  wire logic [PIX_W-1:0]       OFFSET_REFERENCE_B,
  input  wire logic [BUS_W-1:0]       PIXEL_SAMPLE,
  output logic [COL_W-1:0]            COLUMN_GROUP,
  output logic [ROW_W-1:0]            ROW_SELECT,
  output logic                        ADC_CALIBRATE,
  output logic                        SENSE_ENABLE,
  output logic                        LOW_POWER
);

  // ------------------------------------------------------------------
  // shared
  // ------------------------------------------------------------------
  // saturating per-pixel subtraction; a negative result clips to black
  function automatic logic [BUS_W-1:0] sub_offset(input logic [BUS_W-1:0] g,
                                                  input logic [PIX_W-1:0] off);
    logic [BUS_W-1:0] r;
    r = '0;
    for (int i = 0; i < GROUP_PIX; i++)
    begin
      if (g[i*PIX_W +: PIX_W] > off)
      begin
        r[i*PIX_W +: PIX_W] = g[i*PIX_W +: PIX_W] - off;
      end
    end
    return r;
  endfunction

  // both domains fall to the low logic reset without any clock
  logic any_rst;
  assign any_rst = RST | ~LOGIC_RESET_LOW;

  // two converted rows; the link reads one bank while the core fills the other
  logic [BUS_W-1:0] row_mem [0:2*(1<<COL_W)-1];
  logic [BUS_W-1:0] wr_data;
  logic [PIX_W-1:0] offset;

  link_t lk;
  link_t next_lk;
  core_t cs;
  core_t next_cs;

  // ------------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------------
  always_comb
  begin
    next_lk = lk;
    // a start counts once, on its second consecutive low cycle
    next_lk.cal_run  = CALIB_BEGIN_PULSE_N ? 2'h0 : (lk.cal_run == 2'h3 ? lk.cal_run
                                                      : lk.cal_run + 2'h1);
    next_lk.conv_run = ROW_CONVERT_PULSE_N ? 2'h0 : (lk.conv_run == 2'h3 ? lk.conv_run
                                                      : lk.conv_run + 2'h1);
    if (!CALIB_BEGIN_PULSE_N && lk.cal_run == 2'h1)
    begin
      next_lk.cal_req = ~lk.cal_req;
    end
    if (!ROW_CONVERT_PULSE_N && lk.conv_run == 2'h1)
    begin
      next_lk.conv_req = ~lk.conv_req;
    end
    next_lk.cal_ack  = {lk.cal_ack[1:0], cs.cal_ack};
    next_lk.conv_ack = {lk.conv_ack[1:0], cs.conv_ack};
    next_lk.cal_done_n = (lk.cal_ack[2] != lk.cal_ack[1]) ? PULSE_FIRE
                         : {lk.cal_done_n[0], 1'b1};
    next_lk.row_done_n = (lk.conv_ack[2] != lk.conv_ack[1]) ? PULSE_FIRE
                         : {lk.row_done_n[0], 1'b1};
    if (lk.conv_ack[2] != lk.conv_ack[1])
    begin
      next_lk.latest_bank = ~lk.latest_bank;
    end
    next_lk.sense = ~ROW_LOAD_ENVELOPE_N;
    if (!ROW_LOAD_ENVELOPE_N)
    begin
      next_lk.bank = lk.latest_bank;
      next_lk.col  = '0;
    end
    else if (!READ_ENABLE_N)
    begin
      // bit 0 is the lowest pixel's LSB, as stored by the core
      next_lk.data = row_mem[{lk.bank, lk.col}];
      next_lk.col  = (lk.col == LAST_GROUP) ? lk.col : lk.col + 7'h01;
    end
  end

  always_ff @(posedge MASTER_CLOCK_IN or posedge any_rst)
  begin
    if (any_rst)
    begin
      // the first row done flips this onto bank 0, the bank the core fills first
      lk <= '{cal_done_n: PULSE_IDLE, row_done_n: PULSE_IDLE, latest_bank: 1'h1,
              default: '0};
    end
    else
    begin
      lk <= next_lk;
    end
  end

  assign CALIB_DONE_N  = lk.cal_done_n[1];
  assign ROW_DONE_N    = lk.row_done_n[1];
  assign PIXEL_DATA    = lk.data;
  assign SENSE_ENABLE  = lk.sense;
  // data changes on the rising master edge, so the inverted clock centres it
  assign PIXEL_CLK_OUT = ~MASTER_CLOCK_IN;

  // ------------------------------------------------------------------
  // core domain
  // ------------------------------------------------------------------
  assign offset  = (cs.ref_s2[2*PIX_W-1:PIX_W] > cs.ref_s2[PIX_W-1:0])
                   ? cs.ref_s2[2*PIX_W-1:PIX_W] - cs.ref_s2[PIX_W-1:0] : '0;
  // an undriven pin reads high through its pull-up and leaves data raw
  assign wr_data = cs.dark[1] ? PIXEL_SAMPLE : sub_offset(PIXEL_SAMPLE, offset);

  always_comb
  begin
    next_cs = cs;
    next_cs.cal_req  = {cs.cal_req[1:0], lk.cal_req};
    next_cs.conv_req = {cs.conv_req[1:0], lk.conv_req};
    next_cs.standby  = {cs.standby[0], STANDBY_N};
    next_cs.dark     = {cs.dark[0], DARK_OFFSET_EN_N};
    next_cs.addr_s1  = ROW_ADDRESS;
    next_cs.addr_s2  = cs.addr_s1;
    next_cs.ref_s1   = {OFFSET_REFERENCE_A, OFFSET_REFERENCE_B};
    next_cs.ref_s2   = cs.ref_s1;
    unique case (cs.state)
      CORE_IDLE:
      begin
        // requests made in standby are dropped, not queued
        if (cs.standby[1])
        begin
          if (cs.cal_req[2] != cs.cal_req[1])
          begin
            next_cs.state = CORE_CAL;
            next_cs.cnt   = '0;
          end
          else if (cs.conv_req[2] != cs.conv_req[1])
          begin
            next_cs.state   = CORE_CONV;
            next_cs.row_sel = cs.addr_s2;
            next_cs.grp     = '0;
          end
        end
      end
      CORE_CAL:
      begin
        next_cs.cnt = cs.cnt + 9'h001;
        if (cs.cnt == CAL_LAST)
        begin
          next_cs.state   = CORE_IDLE;
          next_cs.cal_ack = ~cs.cal_ack;
        end
      end
      CORE_CONV:
      begin
        next_cs.grp = cs.grp + 7'h01;
        if (cs.grp == LAST_GROUP)
        begin
          next_cs.state    = CORE_IDLE;
          next_cs.wr_bank  = ~cs.wr_bank;
          next_cs.conv_ack = ~cs.conv_ack;
        end
      end
      default:
      begin
        next_cs.state = CORE_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge any_rst)
  begin
    if (any_rst)
    begin
      cs <= '{state: CORE_IDLE, standby: 2'h3, dark: 2'h3, default: '0};
    end
    else
    begin
      cs <= next_cs;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (cs.state == CORE_CONV)
    begin
      row_mem[{cs.wr_bank, cs.grp}] <= wr_data;
    end
  end

  assign COLUMN_GROUP  = cs.grp;
  assign ROW_SELECT    = cs.row_sel;
  assign ADC_CALIBRATE = (cs.state == CORE_CAL);
  assign LOW_POWER     = ~cs.standby[1];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence two_low_then_high(sig);
    !sig ##1 sig;
  endsequence

  AST_CAL_DONE_WIDTH: assert property (@(posedge MASTER_CLOCK_IN) disable iff (any_rst)
    $fell(CALIB_DONE_N) |=> two_low_then_high(CALIB_DONE_N))
    else $error("calibration done pulse not two cycles");

  AST_ROW_DONE_WIDTH: assert property (@(posedge MASTER_CLOCK_IN) disable iff (any_rst)
    $fell(ROW_DONE_N) |=> two_low_then_high(ROW_DONE_N))
    else $error("row done pulse not two cycles");

  AST_LOAD_RESETS_COL: assert property (@(posedge MASTER_CLOCK_IN) disable iff (any_rst)
    !ROW_LOAD_ENVELOPE_N |=> lk.col == '0 && SENSE_ENABLE && lk.bank == $past(lk.latest_bank))
    else $error("load envelope did not load the row");

  AST_READ_ADVANCE: assert property (@(posedge MASTER_CLOCK_IN) disable iff (any_rst)
    ROW_LOAD_ENVELOPE_N && !READ_ENABLE_N && lk.col != LAST_GROUP
    |=> lk.col == $past(lk.col) + 7'h01)
    else $error("column counter did not advance");

  AST_READ_HOLD: assert property (@(posedge MASTER_CLOCK_IN) disable iff (any_rst)
    READ_ENABLE_N && ROW_LOAD_ENVELOPE_N |=> $stable(PIXEL_DATA) && $stable(lk.col))
    else $error("output moved with read disabled");

  AST_DARK_SUB: assert property (@(posedge MCLK) disable iff (any_rst)
    !cs.dark[1] && PIXEL_SAMPLE[PIX_W-1:0] > offset
    |-> wr_data[PIX_W-1:0] == PIXEL_SAMPLE[PIX_W-1:0] - offset)
    else $error("dark offset not subtracted");

  AST_DARK_OFF_RAW: assert property (@(posedge MCLK) disable iff (any_rst)
    cs.dark[1] |-> wr_data == PIXEL_SAMPLE)
    else $error("data altered with dark offset disabled");

  AST_STANDBY_IDLE: assert property (@(posedge MCLK) disable iff (any_rst)
    !cs.standby[1] && cs.state == CORE_IDLE |=> cs.state == CORE_IDLE)
    else $error("core left idle during standby");

  AST_ROW_LATCH: assert property (@(posedge MCLK) disable iff (any_rst)
    cs.state == CORE_IDLE ##1 cs.state == CORE_CONV |-> ROW_SELECT == $past(cs.addr_s2))
    else $error("row select not the sampled address");

  AST_CONV_LENGTH: assert property (@(posedge MCLK) disable iff (any_rst)
    cs.state == CORE_IDLE ##1 cs.state == CORE_CONV |-> ##127 cs.state == CORE_CONV ##1
    cs.state == CORE_IDLE)
    else $error("conversion not 128 groups");

endmodule
`default_nettype wire

/* File: dv/sensor_ctrl_model.sv */
/*
  Behavioural model of the external controller that drives the link pins.
  Assumes its tasks are called from the link clock's falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sensor_ctrl_model
(
  // link clock
  input  wire logic lclk,
  // controller outputs
  output logic      logic_reset_low,
  output logic      cal_n,
  output logic      conv_n,
  output logic      load_n,
  output logic      read_n
);
  initial
  begin
    logic_reset_low = 1'b0;
    cal_n  = 1'b1;
    conv_n = 1'b1;
    load_n = 1'b1;
    read_n = 1'b1;
  end
  // strobes stay low for exactly two link cycles, never longer
  task pulse(input logic calib);
    @(negedge lclk);
    if (calib) cal_n = 1'b0;
    else conv_n = 1'b0;
    repeat (2) @(negedge lclk);
    cal_n  = 1'b1;
    conv_n = 1'b1;
  endtask
  task load_row;
    @(negedge lclk);
    load_n = 1'b0;
    @(negedge lclk);
    load_n = 1'b1;
    read_n = 1'b0;
  endtask
  task set_read(input logic v);
    read_n = v;
  endtask
  task set_reset(input logic v);
    logic_reset_low = v;
  endtask
endmodule
`default_nettype wire

/* File: dv/pixel_row_readout_control_tb.sv */
/*
  Self-checking bench: row conversions and readouts, read pause, standby,
  calibration and resets. Assumes the controller model owns the reset and strobe
  link pins, the bench drives DARK_OFFSET_EN_N, STANDBY_N and ROW_ADDRESS, and
  the bench stands in for the ADC array on PIXEL_SAMPLE.
*/
`timescale 1ns/1ns
`default_nettype none
module pixel_row_readout_control_tb;
  import pixel_readout_pkg::*;
  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic             dark_n;
    logic [PIX_W-1:0] ref_a;
    logic [PIX_W-1:0] ref_b;
  } row_case_t;
  logic             MCLK = 1'b0;
  logic             RST = 1'b1;
  logic             lclk = 1'b0;
  logic             dark_n = 1'b1;
  logic             stby_n = 1'b1;
  logic [ROW_W-1:0] addr = '0;
  logic [PIX_W-1:0] ref_a = 10'h005;
  logic [PIX_W-1:0] ref_b = 10'h002;
  logic [BUS_W-1:0] sample;
  logic [BUS_W-1:0] pdata;
  logic [COL_W-1:0] grp;
  logic [ROW_W-1:0] rsel;
  logic             logic_reset_low, cal_n, conv_n, load_n, read_n;
  logic             cal_done_n, row_done_n, pclk, adc_cal, sense, low_pwr;
  int               bad_count = 0;
  int               tests_run = 0;
  int               cycles = 0;
  int               w;
  // the last row has the second reference above the first, so the offset clips to zero
  row_case_t        cases [4] = '{'{10'h000, 1'b1, 10'h005, 10'h002},
                                  '{10'h3ff, 1'b0, 10'h005, 10'h002},
                                  '{10'h155, 1'b1, 10'h011, 10'h001},
                                  '{10'h2aa, 1'b0, 10'h003, 10'h007}};
  row_case_t        after_rst = '{10'h0f0, 1'b0, 10'h030, 10'h010};

  always #2 MCLK = ~MCLK;
  initial
  begin
    #13;
    forever #80 lclk = ~lclk;
  end

  // pattern stays above every offset used here, so pixels never clip to black
  function automatic logic [BUS_W-1:0] grp_val(input int g, input int off);
    logic [BUS_W-1:0] r;
    for (int i = 0; i < GROUP_PIX; i++)
      r[i*PIX_W +: PIX_W] = PIX_W'(64 + 4*g + i - off);
    return r;
  endfunction
  // offset is the first reference minus the second, never below zero
  function automatic int exp_off(input row_case_t c);
    if (c.dark_n || c.ref_a <= c.ref_b)
      return 0;
    return int'(c.ref_a) - int'(c.ref_b);
  endfunction
  always_comb sample = grp_val(int'(grp), 0);

  sensor_ctrl_model ctrl_u (.lclk(lclk), .logic_reset_low(logic_reset_low), .cal_n(cal_n), .conv_n(conv_n),
    .load_n(load_n), .read_n(read_n));
  pixel_row_readout_control dut_u (.MCLK(MCLK), .RST(RST), .MASTER_CLOCK_IN(lclk),
    .LOGIC_RESET_LOW(logic_reset_low), .CALIB_BEGIN_PULSE_N(cal_n), .CALIB_DONE_N(cal_done_n),
    .ROW_CONVERT_PULSE_N(conv_n), .ROW_DONE_N(row_done_n), .ROW_LOAD_ENVELOPE_N(load_n),
    .READ_ENABLE_N(read_n), .DARK_OFFSET_EN_N(dark_n), .STANDBY_N(stby_n),
    .ROW_ADDRESS(addr), .PIXEL_DATA(pdata), .PIXEL_CLK_OUT(pclk),
    .OFFSET_REFERENCE_A(ref_a), .OFFSET_REFERENCE_B(ref_b), .PIXEL_SAMPLE(sample),
    .COLUMN_GROUP(grp), .ROW_SELECT(rsel), .ADC_CALIBRATE(adc_cal),
    .SENSE_ENABLE(sense), .LOW_POWER(low_pwr));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check_vec(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t bus got %h exp %h", $time, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp);
    check_vec(BUS_W'(got), BUS_W'(exp));
  endtask
  task check_int(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      bad_count++;
      $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask
  // bounded wait for a done strobe, then its width in link cycles
  task pulse_width(input logic sel, input int limit, output int wd);
    int n;
    n = 0;
    wd = 0;
    while ((sel ? cal_done_n : row_done_n) !== 1'b0 && n < limit)
    begin
      @(negedge lclk);
      n++;
    end
    while ((sel ? cal_done_n : row_done_n) === 1'b0)
    begin
      @(negedge lclk);
      wd++;
    end
  endtask

  // convert one row, then drain it; an optional read pause mid-row
  task automatic run_row(input row_case_t c, input bit pause);
    int wd;
    int off;
    off = exp_off(c);
    @(negedge MCLK);
    dark_n = c.dark_n;
    ref_a  = c.ref_a;
    ref_b  = c.ref_b;
    addr   = c.row;
    repeat (2) @(negedge lclk);
    ctrl_u.pulse(1'b0);
    pulse_width(1'b0, 20, wd);
    check_int(wd, 2);
    check_vec(BUS_W'(rsel), BUS_W'(c.row));
    ctrl_u.load_row();
    check_bit(sense, 1'b1);
    for (int g = 0; g < 128; g++)
    begin
      @(negedge lclk);
      check_vec(pdata, grp_val(g, off));
      if (pause && g == 49)
      begin
        ctrl_u.set_read(1'b1);
        repeat (3) @(negedge lclk) check_vec(pdata, grp_val(g, off));
        ctrl_u.set_read(1'b0);
      end
    end
    ctrl_u.set_read(1'b1);
  endtask

  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end

  initial
  begin
    repeat (20) @(posedge MCLK);
    check_vec(pdata, '0);
    check_bit(row_done_n, 1'b1);
    @(negedge MCLK) RST = 1'b0;
    repeat (2) @(negedge lclk);
    ctrl_u.set_reset(1'b1);
    repeat (3) @(negedge lclk);
    foreach (cases[k])
    begin
      run_row(cases[k], k == 1);
    end
    @(posedge lclk) #3 check_bit(pclk, 1'b0);
    @(negedge lclk) #3 check_bit(pclk, 1'b1);
    @(negedge MCLK) stby_n = 1'b0;
    repeat (4) @(negedge MCLK);
    check_bit(low_pwr, 1'b1);
    ctrl_u.pulse(1'b0);
    pulse_width(1'b0, 20, w);
    check_int(w, 0);
    @(negedge MCLK) stby_n = 1'b1;
    repeat (4) @(negedge MCLK);
    check_bit(low_pwr, 1'b0);
    repeat (250) @(negedge MCLK);
    ctrl_u.pulse(1'b1);
    repeat (3) @(negedge lclk);
    check_bit(adc_cal, 1'b1);
    pulse_width(1'b1, 40, w);
    check_int(w, 2);
    ctrl_u.set_reset(1'b0);
    #20;
    check_vec(pdata, '0);
    check_vec(BUS_W'(rsel), '0);
    repeat (2) @(negedge lclk);
    ctrl_u.set_reset(1'b1);
    check_bit(cal_done_n, 1'b1);
    check_bit(row_done_n, 1'b1);
    // a row after the mid-run reset must read back the bank it just filled
    run_row(after_rst, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
